// file: rtl/tcm_edge_detect.sv
`timescale 1ns/10ps
`include "tcm_map.svh"
module tcm_edge_detect (
  input  logic              clock_in,
  input  logic              reset_n_in,
  input  logic              pin_in,
  input  logic [1:0]        cis_in,
  tcm_evt_if.edg            evt
);
  import tcm_pkg::*;

  logic pin_q;

  // Previous pin level; the pin is already synchronous
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) pin_q <= 1'b0;
    else pin_q <= pin_in;
  end

  // Edge qualification by the edge select field
  assign evt.rise = pin_in & ~pin_q;
  assign evt.fall = ~pin_in & pin_q;
  assign evt.valid_edge =
    (cis_in == `TCM_CIS_FALL) ? evt.fall :
    (cis_in == `TCM_CIS_RISE) ? evt.rise :
    (evt.rise | evt.fall);

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);

  fall_edge_a: assert property (
    cis_in == `TCM_CIS_FALL && evt.valid_edge |->
      $past(pin_in) && !pin_in)
    else $error("falling edge select passed a rise");
  rise_edge_a: assert property (
    cis_in == `TCM_CIS_RISE && !$past(pin_in) && pin_in |->
      evt.valid_edge)
    else $error("rising edge select missed a rise");
endmodule : tcm_edge_detect

// file: rtl/tcm_evt_if.sv
`timescale 1ns/10ps
// Ticks and pin edges handed to the channel core
interface tcm_evt_if;
  logic tick_a;
  logic tick_b;
  logic rise;
  logic fall;
  logic valid_edge;
  modport pre  (output tick_a, tick_b);
  modport edg  (output rise, fall, valid_edge);
  modport core (input tick_a, tick_b, rise, fall, valid_edge);
endinterface : tcm_evt_if

// file: rtl/tcm_map.svh
`ifndef TCM_MAP_SVH
`define TCM_MAP_SVH
// Register byte offsets
`define TCM_OFF_MODE_HI  8'h00
`define TCM_OFF_MODE_LO  8'h04
`define TCM_OFF_IRQ_FLAG 8'h08
`define TCM_OFF_IRQ_MASK 8'h0C
`define TCM_OFF_START    8'h10
`define TCM_OFF_STOP     8'h14
`define TCM_OFF_PRESCALE 8'h18
`define TCM_OFF_STATUS   8'h1C
`define TCM_OFF_COUNT    8'h20
`define TCM_OFF_DATA     8'h24
// Field positions
`define TCM_OPCLK_BIT    7
`define TCM_CCS_BIT      4
`define TCM_TRIG_RANGE   2:0
`define TCM_CIS_RANGE    7:6
`define TCM_MD_RANGE     3:1
`define TCM_LSB_BIT      0
`define TCM_FLAG_BIT     7
`define TCM_MASK_BIT     7
`define TCM_START_BIT    0
`define TCM_STOP_BIT     0
`define TCM_EN_BIT       0
`define TCM_PSA_RANGE    3:0
`define TCM_PSB_RANGE    7:4
// Writable bits and reset values
`define TCM_MODE_HI_WMASK 8'h97
`define TCM_MODE_LO_WMASK 8'hCF
`define TCM_MODE_RST      8'h00
`define TCM_PRESCALE_RST  8'h00
`define TCM_MASK_RST      1'b1
`define TCM_CNT_ZERO      16'h0000
`define TCM_CNT_ONE       16'h0001
`define TCM_WORD_ZERO     32'h0000_0000
// Trigger select and edge codes
`define TCM_TRIG_SW       3'h0
`define TCM_TRIG_EDGE     3'h1
`define TCM_TRIG_BOTH     3'h2
`define TCM_TRIG_MASTER   3'h4
`define TCM_CIS_FALL      2'h0
`define TCM_CIS_RISE      2'h1
`define TCM_CIS_BOTH_LOW  2'h2
`define TCM_CIS_BOTH_HIGH 2'h3
`endif

// file: rtl/tcm_pkg.sv
package tcm_pkg;
  typedef logic [7:0]  tcm_addr_t;
  typedef logic [31:0] tcm_word_t;
  typedef logic [15:0] tcm_cnt_t;
  typedef logic [14:0] tcm_pre_t;
  // Upper three bits of the mode field
  typedef enum logic [2:0] {
    TCM_MD_INTERVAL = 3'b000,
    TCM_MD_CAPTURE  = 3'b010,
    TCM_MD_EVENT    = 3'b011,
    TCM_MD_ONECNT   = 3'b100,
    TCM_MD_CAPONE   = 3'b110
  } tcm_mode_t;
  typedef enum logic [1:0] {
    TCM_ST_IDLE = 2'b00,
    TCM_ST_WAIT = 2'b01,
    TCM_ST_RUN  = 2'b10
  } tcm_state_t;
endpackage : tcm_pkg

// file: rtl/tcm_prescaler.sv
`timescale 1ns/10ps
`include "tcm_map.svh"
module tcm_prescaler (
  input  logic              clock_in,
  input  logic              reset_n_in,
  input  logic [3:0]        sel_a_in,
  input  logic [3:0]        sel_b_in,
  tcm_evt_if.pre            evt
);
  import tcm_pkg::*;

  tcm_pre_t div_q;

  // Tick when the low sel bits are all ones: period of 2**sel
  function automatic logic tick_hit(input tcm_pre_t c,
                                    input logic [3:0] s);
    tcm_pre_t m;
    m = tcm_pre_t'((16'h0001 << s) - 16'h0001);
    tick_hit = ((c & m) == m);
  endfunction : tick_hit

  // Free running divider shared by both outputs
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) div_q <= '0;
    else div_q <= div_q + tcm_pre_t'(1);
  end

  assign evt.tick_a = tick_hit(div_q, sel_a_in);
  assign evt.tick_b = tick_hit(div_q, sel_b_in);

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);

  sequence seq_half_rate;
    !evt.tick_a ##1 evt.tick_a;
  endsequence

  full_rate_a: assert property (
    sel_a_in == 4'h0 |-> evt.tick_a)
    else $error("prescaler ratio one does not tick");
  half_rate_a: assert property (
    sel_a_in == 4'h1 && $stable(sel_a_in) && evt.tick_a
      ##1 sel_a_in == 4'h1 |-> seq_half_rate)
    else $error("prescaler ratio two has wrong period");
endmodule : tcm_prescaler

// file: rtl/tcm_timer_channel.sv
`timescale 1ns/10ps
`include "tcm_map.svh"
// Notes on behaviour
// - Mode high bit 7 picks prescaled clock a or b as operation clock.
// - Count clock bit 4: 0 operation clock, 1 valid input pin edges.
// - Trigger select 000 accepts only the software start trigger.
// - Code 001: valid edge starts and captures; 010: both edges do.
// - Code 100: master channel interrupt is the trigger for a slave.
// - Edge select: 00 fall, 01 rise, 10 and 11 both edges.
// - Mode field selects interval, capture, event, one-count, capture-one.
// - Interval/capture: LSB 1 gives interrupt and output toggle at start.
// - One-count: LSB 0 ignores retrigger, LSB 1 reloads and interrupts.
// - Capture-one-count: no start interrupt, retrigger while counting ignored.
// - Interrupt request flag reads 1 while a request is pending.
// - Interrupt mask 0 lets the request through, 1 blocks it.
// - Writing 1 to start sets enable status and enables counting.
// - Capture: copy counter to data, interrupt, clear counter; only capture-one then waits.
// - Writing 1 to stop halts the channel; 0 does nothing.
// - Prescaled clock is peripheral clock over 2**n, n from four bits.
module tcm_timer_channel (
  input  logic              clock_in,
  input  logic              reset_n_in,
  input  tcm_pkg::tcm_addr_t paddr_in,
  input  logic              psel_in,
  input  logic              penable_in,
  input  logic              pwrite_in,
  input  tcm_pkg::tcm_word_t pwdata_in,
  output tcm_pkg::tcm_word_t prdata_out,
  output logic              pready_out,
  output logic              pslverr_out,
  input  logic              timer_input_pin_in,
  input  logic              master_irq_in,
  output logic              timer_out_out,
  output logic              chan_irq_out
);
  import tcm_pkg::*;

  tcm_evt_if evt_if ();

  // Register state
  logic [7:0] mode_hi_q;
  logic [7:0] mode_lo_q;
  logic [7:0] prescale_q;
  logic       flag_q;
  logic       flag_d;
  logic       mask_q;
  logic       en_q;
  logic       en_d;
  logic       tout_q;
  logic       tout_d;
  tcm_cnt_t   cnt_q;
  tcm_cnt_t   cnt_d;
  tcm_cnt_t   data_q;
  tcm_cnt_t   data_d;
  tcm_word_t  rdata_q;
  tcm_state_t st_q;
  tcm_state_t st_d;
  logic       irq_set;
  logic       tog;

  tcm_prescaler u_pre (
    .clock_in   (clock_in),
    .reset_n_in (reset_n_in),
    .sel_a_in   (prescale_q[`TCM_PSA_RANGE]),
    .sel_b_in   (prescale_q[`TCM_PSB_RANGE]),
    .evt        (evt_if.pre)
  );

  tcm_edge_detect u_edge (
    .clock_in   (clock_in),
    .reset_n_in (reset_n_in),
    .pin_in     (timer_input_pin_in),
    .cis_in     (mode_lo_q[`TCM_CIS_RANGE]),
    .evt        (evt_if.edg)
  );

  // APB decode; access phase always completes in one cycle
  wire setup    = psel_in & ~penable_in;
  wire access   = psel_in & penable_in;
  wire wr       = access & pwrite_in;
  wire rd       = access & ~pwrite_in;
  wire hit_mhi  = paddr_in == `TCM_OFF_MODE_HI;
  wire hit_mlo  = paddr_in == `TCM_OFF_MODE_LO;
  wire hit_flag = paddr_in == `TCM_OFF_IRQ_FLAG;
  wire hit_mask = paddr_in == `TCM_OFF_IRQ_MASK;
  wire hit_sta  = paddr_in == `TCM_OFF_START;
  wire hit_sto  = paddr_in == `TCM_OFF_STOP;
  wire hit_pre  = paddr_in == `TCM_OFF_PRESCALE;
  wire hit_stat = paddr_in == `TCM_OFF_STATUS;
  wire hit_cnt  = paddr_in == `TCM_OFF_COUNT;
  wire hit_data = paddr_in == `TCM_OFF_DATA;
  wire hit_any  = hit_mhi | hit_mlo | hit_flag | hit_mask | hit_sta |
                  hit_sto | hit_pre | hit_stat | hit_cnt | hit_data;
  assign pready_out  = access;
  assign pslverr_out = access & ~hit_any;

  // Write strobes that act beyond storing a value
  wire start_wr = wr & hit_sta & pwdata_in[`TCM_START_BIT];
  wire stop_wr  = wr & hit_sto & pwdata_in[`TCM_STOP_BIT];
  wire wr_any   = start_wr | stop_wr;

  // Read mux; write-only start and stop read as zero
  wire [7:0]  flag_byte = {flag_q, 7'h00};
  wire [7:0]  mask_byte = {mask_q, 7'h00};
  wire tcm_word_t rmux =
    hit_mhi  ? {24'h00_0000, mode_hi_q}  :
    hit_mlo  ? {24'h00_0000, mode_lo_q}  :
    hit_flag ? {24'h00_0000, flag_byte}  :
    hit_mask ? {24'h00_0000, mask_byte}  :
    hit_pre  ? {24'h00_0000, prescale_q} :
    hit_stat ? {31'h0000_0000, en_q}     :
    hit_cnt  ? {16'h0000, cnt_q}         :
    hit_data ? {16'h0000, data_q}        : `TCM_WORD_ZERO;
  assign prdata_out = rdata_q;

  // Mode field views
  wire [2:0] trig    = mode_hi_q[`TCM_TRIG_RANGE];
  wire [1:0] cis     = mode_lo_q[`TCM_CIS_RANGE];
  wire       lsb     = mode_lo_q[`TCM_LSB_BIT];
  wire [2:0] md      = mode_lo_q[`TCM_MD_RANGE];
  wire is_int   = md == TCM_MD_INTERVAL;
  wire is_cap   = md == TCM_MD_CAPTURE;
  wire is_evt   = md == TCM_MD_EVENT;
  wire is_one   = md == TCM_MD_ONECNT;
  wire is_capone = md == TCM_MD_CAPONE;
  wire up_mode  = is_cap | is_capone;
  wire one_mode = is_one | is_capone;
  // Prohibited codes, including LSB 1 with event or capture-one
  wire mode_ok  = is_int | is_cap | (is_evt & ~lsb) | is_one |
                  (is_capone & ~lsb);
  // Start interrupt only in interval and capture modes
  wire start_irq = (is_int | is_cap) & lsb;

  // Count clock: prescaled clock or pin edges
  wire opclk = mode_hi_q[`TCM_OPCLK_BIT] ? evt_if.tick_b
                                         : evt_if.tick_a;
  wire tick  = mode_hi_q[`TCM_CCS_BIT] ? evt_if.valid_edge
                                       : opclk;

  // Split start and capture edges for width measurement
  wire low_w   = cis == `TCM_CIS_BOTH_LOW;
  wire high_w  = cis == `TCM_CIS_BOTH_HIGH;
  wire st_edge = low_w ? evt_if.fall :
                 high_w ? evt_if.rise : evt_if.valid_edge;
  wire cp_edge = low_w ? evt_if.rise :
                 high_w ? evt_if.fall : evt_if.valid_edge;

  // Trigger routing; unused codes give no hardware trigger
  wire trig_sw = trig == `TCM_TRIG_SW;
  wire start_evt =
    (trig == `TCM_TRIG_EDGE)   ? evt_if.valid_edge :
    (trig == `TCM_TRIG_BOTH)   ? st_edge :
    (trig == `TCM_TRIG_MASTER) ? master_irq_in : 1'b0;
  wire cap_evt =
    (trig == `TCM_TRIG_EDGE)   ? evt_if.valid_edge :
    (trig == `TCM_TRIG_BOTH)   ? cp_edge :
    (trig == `TCM_TRIG_MASTER) ? master_irq_in : 1'b0;

  // Value loaded when counting begins
  wire tcm_cnt_t load_val = up_mode ? `TCM_CNT_ZERO : data_q;
  wire cnt_zero = cnt_q == `TCM_CNT_ZERO;

  // Channel sequencer and counter; stop wins over start
  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    data_d  = data_q;
    irq_set = 1'b0;
    tog     = 1'b0;
    if (stop_wr) begin
      st_d = TCM_ST_IDLE;
    end else if (start_wr) begin
      if (one_mode && !trig_sw) begin
        st_d = TCM_ST_WAIT;
      end else begin
        st_d    = TCM_ST_RUN;
        cnt_d   = load_val;
        irq_set = start_irq;
        tog     = start_irq;
      end
    end else begin
      unique case (st_q)
        TCM_ST_IDLE: begin
          st_d = TCM_ST_IDLE;
        end
        TCM_ST_WAIT: begin
          if (start_evt && !trig_sw) begin
            st_d  = TCM_ST_RUN;
            cnt_d = load_val;
          end
        end
        TCM_ST_RUN: begin
          if (!mode_ok) begin
            cnt_d = cnt_q;
          end else if (up_mode && cap_evt) begin
            data_d  = cnt_q;
            cnt_d   = `TCM_CNT_ZERO;
            irq_set = 1'b1;
            if (is_capone) st_d = TCM_ST_WAIT;
          end else if (up_mode) begin
            if (tick) cnt_d = cnt_q + `TCM_CNT_ONE;
          end else if (is_one && lsb && start_evt) begin
            cnt_d   = data_q;
            irq_set = 1'b1;
          end else if (tick && cnt_zero) begin
            irq_set = 1'b1;
            tog     = 1'b1;
            if (is_one) st_d = TCM_ST_WAIT;
            else cnt_d = data_q;
          end else if (tick) begin
            cnt_d = cnt_q - `TCM_CNT_ONE;
          end
        end
        default: st_d = TCM_ST_IDLE;
      endcase
    end
  end

  // Data register write from software, capture takes priority
  wire data_wr = wr & hit_data;
  wire cap_load = (st_q == TCM_ST_RUN) & mode_ok & up_mode & cap_evt & ~wr_any;
  wire tcm_cnt_t data_n = cap_load ? data_d :
                          data_wr ? pwdata_in[15:0] : data_q;

  // Enable status follows start and stop
  assign en_d = stop_wr ? 1'b0 : start_wr ? 1'b1 : en_q;
  assign tout_d = tout_q ^ tog;

  // Sticky flag: set wins over read clear and write zero
  wire flag_rd = rd & hit_flag & rdata_q[`TCM_FLAG_BIT];
  wire flag_wz = wr & hit_flag & ~pwdata_in[`TCM_FLAG_BIT];
  assign flag_d = irq_set | (flag_q & ~flag_rd & ~flag_wz);

  assign chan_irq_out  = flag_q & ~mask_q;
  assign timer_out_out = tout_q;

  // Configuration registers
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      mode_hi_q  <= `TCM_MODE_RST;
      mode_lo_q  <= `TCM_MODE_RST;
      prescale_q <= `TCM_PRESCALE_RST;
      mask_q     <= `TCM_MASK_RST;
    end else if (wr) begin
      if (hit_mhi) mode_hi_q <= pwdata_in[7:0] & `TCM_MODE_HI_WMASK;
      if (hit_mlo) mode_lo_q <= pwdata_in[7:0] & `TCM_MODE_LO_WMASK;
      if (hit_pre) prescale_q <= pwdata_in[7:0];
      if (hit_mask) mask_q <= pwdata_in[`TCM_MASK_BIT];
    end
  end

  // Channel state registers
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      st_q   <= TCM_ST_IDLE;
      cnt_q  <= `TCM_CNT_ZERO;
      data_q <= `TCM_CNT_ZERO;
      en_q   <= 1'b0;
      flag_q <= 1'b0;
      tout_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      data_q <= data_n;
      en_q   <= en_d;
      flag_q <= flag_d;
      tout_q <= tout_d;
    end
  end

  // Read data latched in setup so the output is a flop
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) rdata_q <= `TCM_WORD_ZERO;
    else if (setup) rdata_q <= rmux;
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);

  sequence seq_capture_hit;
    st_q == TCM_ST_RUN && is_cap && mode_ok && cap_evt && !wr_any;
  endsequence

  sequence seq_captured;
    data_q == $past(cnt_q) && cnt_q == `TCM_CNT_ZERO && flag_q;
  endsequence

  sequence seq_quiet_run;
    st_q == TCM_ST_RUN && !wr_any && !data_wr;
  endsequence

  start_sets_en_a: assert property (
    start_wr && !stop_wr |=> en_q && st_q != TCM_ST_IDLE)
    else $error("start write did not enable the channel");

  stop_clears_a: assert property (
    stop_wr |=> !en_q && st_q == TCM_ST_IDLE)
    else $error("stop write did not halt the channel");

  frozen_count_a: assert property (
    !en_q && !start_wr |=> $stable(cnt_q))
    else $error("counter moved while disabled");

  capture_copy_a: assert property (
    seq_capture_hit |=> seq_captured)
    else $error("capture did not copy, clear and flag");

  sw_only_a: assert property (
    st_q == TCM_ST_WAIT && trig_sw && !wr_any |=>
      st_q == TCM_ST_WAIT)
    else $error("hardware trigger started a software channel");

  start_irq_a: assert property (
    start_wr && !stop_wr && (is_int || is_cap) |->
      irq_set == lsb && tog == lsb)
    else $error("start interrupt does not follow the LSB");

  event_start_a: assert property (
    start_wr && is_evt |-> !irq_set)
    else $error("event counter raised interrupt at start");

  onecnt_ignore_a: assert property (
    seq_quiet_run and (is_one && !lsb && start_evt && !tick) |=>
      $stable(cnt_q) && !$rose(flag_q))
    else $error("one-count honoured a retrigger with LSB 0");

  onecnt_retrig_a: assert property (
    seq_quiet_run and (is_one && lsb && start_evt) |=>
      cnt_q == data_q && flag_q)
    else $error("one-count retrigger not reloaded");

  capone_ignore_a: assert property (
    seq_quiet_run and (is_capone && start_evt && !cap_evt) |->
      !irq_set)
    else $error("capture-one-count accepted a retrigger");

  count_clock_a: assert property (
    seq_quiet_run and (is_int && mode_ok && !tick) |=>
      $stable(cnt_q))
    else $error("counter stepped without a count clock");

  opclk_pick_a: assert property (
    !mode_hi_q[`TCM_CCS_BIT] && mode_hi_q[`TCM_OPCLK_BIT] |->
      tick == evt_if.tick_b)
    else $error("operation clock b not selected");

  master_trig_a: assert property (
    trig == `TCM_TRIG_MASTER |->
      start_evt == master_irq_in && cap_evt == master_irq_in)
    else $error("master interrupt not used as trigger");

  edge_trig_a: assert property (
    trig == `TCM_TRIG_EDGE |-> cap_evt == evt_if.valid_edge)
    else $error("valid edge not used as capture trigger");

  prohibited_a: assert property (
    seq_quiet_run and !mode_ok |=> $stable(cnt_q))
    else $error("prohibited mode changed the counter");

  flag_set_a: assert property (
    irq_set |=> flag_q ##1 (flag_q || $past(flag_rd || flag_wz)))
    else $error("interrupt event lost from the flag");

  mask_block_a: assert property (
    mask_q |-> !chan_irq_out)
    else $error("masked request reached the interrupt line");
endmodule : tcm_timer_channel

// file: testbench/tcm_pulse_src.sv
`timescale 1ns/10ps
// Pulse source on the timer input pin; idles low between bursts
module tcm_pulse_src (
  input  wire logic       clock_in,
  input  wire logic       run_in,
  input  wire logic [7:0] half_in,
  output logic            pin_out
);
  logic [7:0] cnt_q = 8'h00;
  logic       pin_q = 1'b0;
  assign pin_out = pin_q;
  // Change only after an edge, so the pin looks synchronous to the core
  always @(posedge clock_in) begin
    if (!run_in) begin
      cnt_q <= 8'h00;
      pin_q <= 1'b0;
    end else if (cnt_q == half_in - 8'h01) begin
      cnt_q <= 8'h00;
      pin_q <= ~pin_q;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule : tcm_pulse_src

// file: testbench/timer_channel_mode_capture_test.sv
`timescale 1ns/10ps
`include "tcm_map.svh"
module timer_channel_mode_capture_test;
  import tcm_pkg::*;
  tcm_addr_t  paddr      = 8'h00;
  tcm_word_t  pwdata     = 32'h0000_0000;
  tcm_word_t  prdata;
  logic       clock_in   = 1'b0;
  logic       reset_n_in = 1'b0;
  logic       psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic       master_irq = 1'b0, run = 1'b0;
  logic       pready, pslverr, pin, tout, irq;
  logic [7:0] half       = 8'h05;
  int         bad_count  = 0, total_checks = 0;

  // Free-running 100 MHz clock
  always #5 clock_in = ~clock_in;

  tcm_timer_channel dut (
    .clock_in(clock_in), .reset_n_in(reset_n_in), .paddr_in(paddr),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .timer_input_pin_in(pin),
    .master_irq_in(master_irq), .timer_out_out(tout), .chan_irq_out(irq));

  tcm_pulse_src src (.clock_in(clock_in), .run_in(run), .half_in(half),
    .pin_out(pin));

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input tcm_word_t got, input tcm_word_t exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit

  // One APB transfer; waits on pready, only the watchdog ends a hang
  task automatic apb(input tcm_addr_t a, input logic w, input tcm_word_t d,
                     output tcm_word_t r, output logic e);
    @(posedge clock_in);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge clock_in);
    penable <= 1'b1;
    @(posedge clock_in);
    while (pready !== 1'b1) begin
      @(posedge clock_in);
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input tcm_addr_t a, input tcm_word_t d);
    tcm_word_t r;
    logic      e;
    apb(a, 1'b1, d, r, e);
  endtask : wr

  task automatic rd(input tcm_addr_t a, output tcm_word_t r);
    logic e;
    apb(a, 1'b0, 32'h0000_0000, r, e);
  endtask : rd

  task automatic wait_irq(input int lim, output logic hit);
    hit = 1'b0;
    for (int i = 0; i < lim && !hit; i++) begin
      @(posedge clock_in);
      hit = (irq === 1'b1);
    end
  endtask : wait_irq

  task automatic t_reset;
    tcm_word_t r;
    logic      e;
    rd(`TCM_OFF_MODE_HI, r);
    chk(r, 32'h0000_0000);
    rd(`TCM_OFF_IRQ_MASK, r);
    chk(r, 32'h0000_0080);
    rd(`TCM_OFF_IRQ_FLAG, r);
    chk(r, 32'h0000_0000);
    rd(`TCM_OFF_STATUS, r);
    chk(r, 32'h0000_0000);
    // Unmapped place must be refused with zero data
    apb(8'h30, 1'b0, 32'h0000_0000, r, e);
    chk_bit(e, 1'b1);
    chk(r, 32'h0000_0000);
    chk_bit(irq, 1'b0);
  endtask : t_reset

  task automatic t_interval;
    tcm_word_t r, c0, c1;
    logic      t0, hit;
    // Masked start: flag is set but the line stays low
    wr(`TCM_OFF_IRQ_MASK, 32'h0000_0080);
    wr(`TCM_OFF_DATA, 32'h0000_0008);
    wr(`TCM_OFF_MODE_HI, 32'h0000_0000);
    wr(`TCM_OFF_MODE_LO, 32'h0000_0001);
    t0 = tout;
    wr(`TCM_OFF_START, 32'h0000_0001);
    #1;
    chk_bit(tout, ~t0);
    chk_bit(irq, 1'b0);
    wr(`TCM_OFF_IRQ_MASK, 32'h0000_0000);
    #1;
    chk_bit(irq, 1'b1);
    rd(`TCM_OFF_IRQ_FLAG, r);
    chk(r, 32'h0000_0080);
    #1;
    chk_bit(irq, 1'b0);
    wait_irq(12, hit);
    chk_bit(hit, 1'b1);
    rd(`TCM_OFF_STATUS, r);
    chk(r, 32'h0000_0001);
    wr(`TCM_OFF_STOP, 32'h0000_0001);
    rd(`TCM_OFF_STATUS, r);
    chk(r, 32'h0000_0000);
    rd(`TCM_OFF_COUNT, c0);
    rd(`TCM_OFF_COUNT, c1);
    chk(c1, c0);
    wr(`TCM_OFF_START, 32'h0000_0000);
    rd(`TCM_OFF_STATUS, r);
    chk(r, 32'h0000_0000);
    // Option bit clear: start raises nothing, output holds
    rd(`TCM_OFF_IRQ_FLAG, r);
    wr(`TCM_OFF_MODE_LO, 32'h0000_0000);
    t0 = tout;
    wr(`TCM_OFF_START, 32'h0000_0001);
    #1;
    chk_bit(tout, t0);
    rd(`TCM_OFF_IRQ_FLAG, r);
    chk(r, 32'h0000_0000);
    wr(`TCM_OFF_STOP, 32'h0000_0001);
  endtask : t_interval

  task automatic t_capture;
    tcm_word_t r;
    logic      hit;
    // Rising then falling edge; pin period 10 cycles gives 9 counts
    for (int k = 1; k >= 0; k--) begin
      wr(`TCM_OFF_MODE_HI, 32'h0000_0001);
      wr(`TCM_OFF_MODE_LO, {24'h00_0000, k[1:0], 6'h04});
      rd(`TCM_OFF_IRQ_FLAG, r);
      wr(`TCM_OFF_START, 32'h0000_0001);
      half <= 8'h05;
      run  <= 1'b1;
      wait_irq(40, hit);
      chk_bit(hit, 1'b1);
      rd(`TCM_OFF_IRQ_FLAG, r);
      wait_irq(40, hit);
      chk_bit(hit, 1'b1);
      rd(`TCM_OFF_DATA, r);
      chk(r, 32'h0000_0009);
      run <= 1'b0;
      wr(`TCM_OFF_STOP, 32'h0000_0001);
    end
  endtask : t_capture

  task automatic t_event;
    tcm_word_t c0, c1;
    // Two rising pin edges must take exactly two counts off
    wr(`TCM_OFF_MODE_HI, 32'h0000_0010);
    wr(`TCM_OFF_MODE_LO, 32'h0000_0046);
    wr(`TCM_OFF_DATA, 32'h0000_0005);
    wr(`TCM_OFF_START, 32'h0000_0001);
    rd(`TCM_OFF_COUNT, c0);
    half <= 8'h04;
    run  <= 1'b1;
    repeat (16) @(posedge clock_in);
    run <= 1'b0;
    repeat (4) @(posedge clock_in);
    rd(`TCM_OFF_COUNT, c1);
    chk(c0, 32'h0000_0005);
    chk(c1, 32'h0000_0003);
    wr(`TCM_OFF_STOP, 32'h0000_0001);
  endtask : t_event

  task automatic t_master;
    tcm_word_t r;
    logic      hit;
    // One-count slave waits for the master pulse before it runs
    wr(`TCM_OFF_MODE_HI, 32'h0000_0004);
    wr(`TCM_OFF_MODE_LO, 32'h0000_0008);
    wr(`TCM_OFF_DATA, 32'h0000_0004);
    rd(`TCM_OFF_IRQ_FLAG, r);
    wr(`TCM_OFF_START, 32'h0000_0001);
    wait_irq(20, hit);
    chk_bit(hit, 1'b0);
    master_irq <= 1'b1;
    @(posedge clock_in);
    master_irq <= 1'b0;
    wait_irq(20, hit);
    chk_bit(hit, 1'b1);
    wr(`TCM_OFF_STOP, 32'h0000_0001);
    // Option bit set: a pulse while counting reloads and interrupts
    wr(`TCM_OFF_MODE_LO, 32'h0000_0009);
    wr(`TCM_OFF_DATA, 32'h0000_0020);
    rd(`TCM_OFF_IRQ_FLAG, r);
    wr(`TCM_OFF_START, 32'h0000_0001);
    for (int p = 0; p < 2; p++) begin
      master_irq <= 1'b1;
      @(posedge clock_in);
      master_irq <= 1'b0;
      wait_irq(4, hit);
      chk_bit(hit, p[0]);
    end
    wr(`TCM_OFF_STOP, 32'h0000_0001);
    rd(`TCM_OFF_IRQ_FLAG, r);
  endtask : t_master

  task automatic t_capone;
    tcm_word_t r;
    logic      hit;
    // Low width: fall starts, rise captures; 6 low cycles give 5 counts
    wr(`TCM_OFF_MODE_HI, 32'h0000_0002);
    wr(`TCM_OFF_MODE_LO, 32'h0000_008C);
    rd(`TCM_OFF_IRQ_FLAG, r);
    wr(`TCM_OFF_START, 32'h0000_0001);
    half <= 8'h06;
    run  <= 1'b1;
    wait_irq(40, hit);
    chk_bit(hit, 1'b1);
    rd(`TCM_OFF_DATA, r);
    chk(r, 32'h0000_0005);
    run <= 1'b0;
    wr(`TCM_OFF_STOP, 32'h0000_0001);
    rd(`TCM_OFF_IRQ_FLAG, r);
  endtask : t_capone

  task automatic t_opclk;
    tcm_word_t c0, c1, d;
    // Clock b at /16: four or five counts over 68 edges; clock a at /2
    wr(`TCM_OFF_PRESCALE, 32'h0000_0041);
    wr(`TCM_OFF_MODE_HI, 32'h0000_0080);
    wr(`TCM_OFF_MODE_LO, 32'h0000_0000);
    wr(`TCM_OFF_DATA, 32'h0000_FFFF);
    wr(`TCM_OFF_START, 32'h0000_0001);
    rd(`TCM_OFF_COUNT, c0);
    repeat (64) @(posedge clock_in);
    rd(`TCM_OFF_COUNT, c1);
    d = 32'h0000_FFFF - c1;
    chk_bit(c0 >= 32'h0000_FFFE, 1'b1);
    chk_bit(d >= 32'h0000_0004 && d <= 32'h0000_0005, 1'b1);
    wr(`TCM_OFF_STOP, 32'h0000_0001);
  endtask : t_opclk

  // Main sequence after a 16-cycle reset
  initial begin
    repeat (16) @(posedge clock_in);
    reset_n_in <= 1'b1;
    t_reset;
    t_interval;
    t_capture;
    t_event;
    t_master;
    t_capone;
    t_opclk;
    give_verdict;
  end

  // Watchdog well beyond the expected few hundred cycles
  initial begin
    #200000;
    bad_count++;
    give_verdict;
  end
endmodule : timer_channel_mode_capture_test
